// [design/jlls_pkg.sv]
package jlls_pkg;
   localparam int NUM_LINKS = 2;
   localparam int NUM_LANES = 2;
   localparam logic [7:0]  THRESH_RST = 8'hff;
   // Printed offsets are register indices; byte address is four times the index.
   localparam logic [11:0] IDX_LINK_PAGE   = 12'h300;
   localparam logic [11:0] IDX_LANE2_STATE = 12'h4b2;
   localparam logic [11:0] IDX_LANE3_STATE = 12'h4b3;
   localparam logic [11:0] IDX_THRESH      = 12'h010;
   localparam logic [11:0] IDX_CNT_CLEAR   = 12'h011;
   localparam logic [11:0] IDX_IRQ_STATUS  = 12'h012;
   localparam logic [11:0] IDX_IRQ_MASK    = 12'h013;
   localparam logic [7:0]  STATE_RST = 8'h00;
   localparam logic [7:0]  PAGE_RST  = 8'h00;
   localparam logic [7:0]  MASK_RST  = 8'h00;
   localparam int BIT_DISP   = 7;
   localparam int BIT_BADC   = 6;
   localparam int BIT_STRAY  = 5;
   localparam int BIT_DESKEW = 4;
   localparam int BIT_ILAS   = 3;
   localparam int BIT_CKSUM  = 2;
   localparam int BIT_FRAME  = 1;
   localparam int BIT_CGS    = 0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/jlls_cnt_if.sv]
`timescale 1ns/1ps
interface jlls_cnt_if;
   logic       err_pulse;
   logic       clear;
   logic [7:0] threshold;
   logic       at_thresh;
   modport owner (output err_pulse, output clear, output threshold, input at_thresh);
   modport cnt   (input err_pulse, input clear, input threshold, output at_thresh);
endinterface

// [design/jlls_err_counter.sv]
`timescale 1ns/1ps
module jlls_err_counter (
   input  wire logic aclk,
   input  wire logic aresetn,
   jlls_cnt_if.cnt   c
);
   logic [7:0] count_q;

   // Saturates so a long burst never wraps back below the threshold.
   always_ff @(posedge aclk) begin
      if (!aresetn || c.clear) begin
         count_q <= 8'h00;
      end else if (c.err_pulse && count_q != 8'hff) begin
         count_q <= count_q + 8'h01;
      end
   end

   assign c.at_thresh = (count_q >= c.threshold);
endmodule

// [design/jlls_top.sv]
// Summary of operation
// - Lane 2 bit 7 is one when disparity error count reaches threshold.
// - Lane 2 bit 6 is one when not-in-table error count reaches threshold.
// - Lane 2 bit 5 is one when unexpected control count reaches threshold.
// - Lane 2 bit 4 is one when interlane deskew achieved.
// - Lane 2 bit 3 is one while initial lane alignment sync achieved.
// - Lane 2 bit 2 is one when configuration checksum is correct.
// - Lane 2 bit 1 is one while frame sync held.
// - Lane 2 bit 0 is one while code group sync held.
// - Lane 3 bit 7 is one when disparity error count reaches threshold.
// - Lane 3 bit 6 is one when not-in-table error count reaches threshold.
// - Lane 3 bit 5 is one when unexpected control count reaches threshold.
// - All status fields show the link chosen by the page register.
// - Lane 3 bits 4 to 0 report lane 3 link state like lane 2.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module jlls_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] lane_err_pulse,
   input  wire logic [19:0] lane_state_in,
   input  wire logic [12:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [12:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq
);
   // Inputs index: link*6 + lane*3 + kind (0 disparity, 1 bad code, 2 stray control).
   // State inputs index: link*10 + lane*5 + bit (4 deskew .. 0 code group).
   logic [11:0] err_s1_q, err_s2_q;
   logic [19:0] st_s1_q, st_s2_q;
   logic [7:0]  page_q;
   logic [7:0]  thresh_q;
   logic [11:0] clear_q;
   logic [7:0]  irq_stat_q;
   logic [7:0]  irq_mask_q;
   logic [11:0] at_thresh;
   logic [15:0] status_all;
   logic [15:0] status_prev_q;
   logic [7:0]  lane2_link_state;
   logic [7:0]  lane3_link_state;
   logic [7:0]  irq_event;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_s1_q <= 12'h000;
         err_s2_q <= 12'h000;
         st_s1_q  <= 20'h00000;
         st_s2_q  <= 20'h00000;
      end else begin
         err_s1_q <= lane_err_pulse;
         err_s2_q <= err_s1_q;
         st_s1_q  <= lane_state_in;
         st_s2_q  <= st_s1_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_cnt
         jlls_cnt_if ci ();
         assign ci.err_pulse   = err_s2_q[gi];
         assign ci.clear       = clear_q[gi];
         assign ci.threshold   = thresh_q;
         assign at_thresh[gi]  = ci.at_thresh;
         jlls_err_counter u_cnt (
            .aclk    (aclk),
            .aresetn (aresetn),
            .c       (ci.cnt)
         );
      end
      for (gi = 0; gi < jlls_pkg::NUM_LINKS; gi++) begin : g_link
         assign status_all[gi*8 +: 8] = {at_thresh[gi*6 + 0],
                                         at_thresh[gi*6 + 1],
                                         at_thresh[gi*6 + 2],
                                         st_s2_q[gi*10 + 4],
                                         st_s2_q[gi*10 + 3],
                                         st_s2_q[gi*10 + 2],
                                         st_s2_q[gi*10 + 1],
                                         st_s2_q[gi*10 + 0]};
      end
   endgenerate

   // Lane 3 of each link reuses the same layout, selected by page bit 0.
   logic [15:0] l3_bits;
   generate
      for (gi = 0; gi < jlls_pkg::NUM_LINKS; gi++) begin : g_l3
         assign l3_bits[gi*8 +: 8] = {at_thresh[gi*6 + 3],
                                      at_thresh[gi*6 + 4],
                                      at_thresh[gi*6 + 5],
                                      st_s2_q[gi*10 + 5 +: 5]};
      end
   endgenerate

   always_comb begin
      lane2_link_state = page_q[0] ? status_all[15:8] : status_all[7:0];
      lane3_link_state = page_q[0] ? l3_bits[15:8] : l3_bits[7:0];
   end

   // Rising edge of any threshold flag in the current page raises an event.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_prev_q <= 16'h0000;
      end else begin
         status_prev_q <= {lane3_link_state, lane2_link_state};
      end
   end
   assign irq_event = {2'h0,
                       lane3_link_state[7:5] & ~status_prev_q[15:13],
                       lane2_link_state[7:5] & ~status_prev_q[7:5]};

   // AXI4-Lite write: accept address and data in any order, respond after both.
   logic        aw_have_q, w_have_q;
   logic [12:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        wr_go;
   logic [11:0] widx;

   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   // The byte address is four times the register index, so the index needs eleven bits.
   assign widx  = {1'h0, aw_addr_q[12:2]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_addr_q    <= 13'h0000;
         w_data_q     <= 32'h00000000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= jlls_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (widx == jlls_pkg::IDX_LINK_PAGE || widx == jlls_pkg::IDX_THRESH ||
                             widx == jlls_pkg::IDX_CNT_CLEAR || widx == jlls_pkg::IDX_IRQ_STATUS ||
                             widx == jlls_pkg::IDX_IRQ_MASK  ||
                             widx == jlls_pkg::IDX_LANE2_STATE ||
                             widx == jlls_pkg::IDX_LANE3_STATE)
                            ? jlls_pkg::RESP_OKAY : jlls_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software registers; writes to the read-only status registers are ignored.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         page_q     <= jlls_pkg::PAGE_RST;
         thresh_q   <= jlls_pkg::THRESH_RST;
         irq_mask_q <= jlls_pkg::MASK_RST;
         clear_q    <= 12'h000;
      end else begin
         clear_q <= 12'h000;
         if (wr_go && w_strb_q[0]) begin
            unique case (widx)
               jlls_pkg::IDX_LINK_PAGE: page_q     <= w_data_q[7:0];
               jlls_pkg::IDX_THRESH:    thresh_q   <= w_data_q[7:0];
               jlls_pkg::IDX_IRQ_MASK:  irq_mask_q <= w_data_q[7:0];
               // Each link holds three lane 2 counters below three lane 3 counters.
               jlls_pkg::IDX_CNT_CLEAR: clear_q    <= {{3{w_data_q[7] | w_data_q[8]}},
                                                      {3{w_data_q[6] | w_data_q[8]}},
                                                      {3{w_data_q[7] | w_data_q[8]}},
                                                      {3{w_data_q[6] | w_data_q[8]}}};
               default: ;
            endcase
         end
      end
   end

   // Sticky status: a new event wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= 8'h00;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((wr_go && w_strb_q[0] &&
                        widx == jlls_pkg::IDX_IRQ_STATUS) ? w_data_q[7:0] : 8'h00)) | irq_event;
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // AXI4-Lite read: one outstanding, data registered.
   logic [11:0] ridx;
   assign ridx = {1'h0, s_axi_araddr[12:2]};
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= jlls_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= jlls_pkg::RESP_OKAY;
         unique case (ridx)
            jlls_pkg::IDX_LINK_PAGE:   s_axi_rdata <= {24'h000000, page_q};
            jlls_pkg::IDX_LANE2_STATE: s_axi_rdata <= {24'h000000, lane2_link_state};
            jlls_pkg::IDX_LANE3_STATE: s_axi_rdata <= {24'h000000, lane3_link_state};
            jlls_pkg::IDX_THRESH:      s_axi_rdata <= {24'h000000, thresh_q};
            jlls_pkg::IDX_IRQ_STATUS:  s_axi_rdata <= {24'h000000, irq_stat_q};
            jlls_pkg::IDX_IRQ_MASK:    s_axi_rdata <= {24'h000000, irq_mask_q};
            jlls_pkg::IDX_CNT_CLEAR:   s_axi_rdata <= 32'h00000000;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= jlls_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// [bench/jlls_sva.sv]
`timescale 1ns/1ps
module jlls_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [12:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [12:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // The byte address is four times the register index.
   localparam logic [12:0] A2 = {jlls_pkg::IDX_LANE2_STATE[10:0], 2'h0};
   localparam logic [12:0] A3 = {jlls_pkg::IDX_LANE3_STATE[10:0], 2'h0};
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence ar_at(logic [12:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   sequence aw_at(logic [12:0] a);
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == a;
   endsequence
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   r_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while busy");
   b_time_a: assert property (aw_at(A2) |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h0)
      else $error("status write not answered okay");
   lane2_read_a: assert property (ar_at(A2) |=>
      s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0)
      else $error("lane two read malformed");
   lane3_read_a: assert property (ar_at(A3) |=>
      s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0)
      else $error("lane three read malformed");
   bad_read_a: assert property (ar_at(13'h03fc) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule
bind jlls_top jlls_sva u_sva (
   .aclk          (aclk),
   .aresetn       (aresetn),
   .s_axi_awaddr  (s_axi_awaddr),
   .s_axi_awvalid (s_axi_awvalid),
   .s_axi_awready (s_axi_awready),
   .s_axi_wvalid  (s_axi_wvalid),
   .s_axi_wready  (s_axi_wready),
   .s_axi_bresp   (s_axi_bresp),
   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_bready  (s_axi_bready),
   .s_axi_araddr  (s_axi_araddr),
   .s_axi_arvalid (s_axi_arvalid),
   .s_axi_arready (s_axi_arready),
   .s_axi_rdata   (s_axi_rdata),
   .s_axi_rresp   (s_axi_rresp),
   .s_axi_rvalid  (s_axi_rvalid),
   .s_axi_rready  (s_axi_rready)
);

// [bench/jlls_lane_src.sv]
`timescale 1ns/1ps
module jlls_lane_src (
   input  wire logic   aclk,
   output logic [11:0] lane_err_pulse,
   output logic [19:0] lane_state_in
);
   initial begin
      lane_err_pulse = 12'h0;
      lane_state_in  = 20'h0;
   end
   task automatic set_state(input logic [19:0] v);
      @(posedge aclk);
      lane_state_in <= v;
   endtask
   // A gap after each pulse keeps two errors from merging into one long pulse.
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(posedge aclk);
         lane_err_pulse <= 12'h001 << k;
         @(posedge aclk);
         lane_err_pulse <= 12'h000;
      end
   endtask
endmodule

// [bench/jlls_top_test.sv]
`timescale 1ns/1ps
module jlls_top_test;
   logic        aclk = 1'h0, aresetn = 1'h0, irq;
   logic [12:0] s_axi_awaddr = 13'h0000, s_axi_araddr = 13'h0000;
   logic [11:0] lane_err_pulse;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [19:0] lane_state_in;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          n_fail = 0, n_compared = 0;
   jlls_top u_dut (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .lane_err_pulse (lane_err_pulse),
      .lane_state_in  (lane_state_in),
      .s_axi_awaddr   (s_axi_awaddr),
      .s_axi_awvalid  (s_axi_awvalid),
      .s_axi_awready  (s_axi_awready),
      .s_axi_wdata    (s_axi_wdata),
      .s_axi_wstrb    (s_axi_wstrb),
      .s_axi_wvalid   (s_axi_wvalid),
      .s_axi_wready   (s_axi_wready),
      .s_axi_bresp    (s_axi_bresp),
      .s_axi_bvalid   (s_axi_bvalid),
      .s_axi_bready   (s_axi_bready),
      .s_axi_araddr   (s_axi_araddr),
      .s_axi_arvalid  (s_axi_arvalid),
      .s_axi_arready  (s_axi_arready),
      .s_axi_rdata    (s_axi_rdata),
      .s_axi_rresp    (s_axi_rresp),
      .s_axi_rvalid   (s_axi_rvalid),
      .s_axi_rready   (s_axi_rready),
      .irq            (irq)
   );
   jlls_lane_src u_src (
      .aclk           (aclk),
      .lane_err_pulse (lane_err_pulse),
      .lane_state_in  (lane_state_in)
   );
   always #50 aclk = ~aclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Ready and answer are sampled at the falling edge, so they hold through the next rise.
   // Bready rises only once the response is seen, so every response has to stand a cycle.
   task automatic wr(input logic [11:0] i, input logic [8:0] d);
      logic a, w, b, v;
      logic [1:0] r;
      int t;
      t = 0;
      s_axi_awaddr <= {i[10:0], 2'h0};
      s_axi_wdata <= {23'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(negedge aclk);
         a = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         v = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         if (a) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
         if (b && !v) s_axi_bready <= 1'h1;
         t++;
      end while (!v && t < 50);
      s_axi_bready <= 1'h0;
      chk(v, 1'h1);
      chk(r, jlls_pkg::RESP_OKAY);
   endtask
   task automatic rd(input logic [11:0] i, input logic [7:0] e,
                     input logic [1:0] er = jlls_pkg::RESP_OKAY);
      logic a, v;
      logic [31:0] d;
      logic [1:0] r;
      int t;
      t = 0;
      s_axi_araddr <= {i[10:0], 2'h0};
      s_axi_arvalid <= 1'h1;
      do begin
         @(negedge aclk);
         a = s_axi_arvalid && s_axi_arready;
         v = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (a) begin
            s_axi_arvalid <= 1'h0;
            s_axi_rready <= 1'h1;
         end
         t++;
      end while (!v && t < 50);
      s_axi_rready <= 1'h0;
      chk(v, 1'h1);
      chk(d, {24'h0, e});
      chk(r, er);
   endtask
   task automatic t_state;
      for (int l = 0; l < 2; l++) for (int b = 0; b < 5; b++) begin
         u_src.set_state(20'h1 << (l * 5 + b));
         repeat (4) @(posedge aclk);
         rd(jlls_pkg::IDX_LANE2_STATE, l == 0 ? 8'h1 << b : 8'h0);
         rd(jlls_pkg::IDX_LANE3_STATE, l == 1 ? 8'h1 << b : 8'h0);
      end
      u_src.set_state(20'h07c20);
      repeat (4) @(posedge aclk);
      rd(jlls_pkg::IDX_LANE3_STATE, 8'h01);
      wr(jlls_pkg::IDX_LINK_PAGE, 8'h01);
      rd(jlls_pkg::IDX_LANE2_STATE, 8'h1f);
      rd(jlls_pkg::IDX_LANE3_STATE, 8'h00);
      wr(jlls_pkg::IDX_LINK_PAGE, 8'h00);
      u_src.set_state(20'h0);
      $display("link state and paging test done");
   endtask
   task automatic t_err;
      logic [15:0] e;
      e = 16'h0;
      wr(jlls_pkg::IDX_THRESH, 8'h03);
      for (int k = 0; k < 6; k++) for (int p = 0; p < 2; p++) begin
         u_src.pulse(k, 2 - p);
         if (p == 1) e[(k / 3) * 8 + 7 - k % 3] = 1'h1;
         repeat (5) @(posedge aclk);
         rd(jlls_pkg::IDX_LANE2_STATE, e[7:0]);
         rd(jlls_pkg::IDX_LANE3_STATE, e[15:8]);
      end
      #1 chk(irq, 1'h0);
      wr(jlls_pkg::IDX_IRQ_MASK, 8'h3f);
      #1 chk(irq, 1'h1);
      wr(jlls_pkg::IDX_IRQ_STATUS, 8'h3f);
      #1 chk(irq, 1'h0);
      wr(jlls_pkg::IDX_LINK_PAGE, 8'h01);
      rd(jlls_pkg::IDX_LANE2_STATE, 8'h00);
      wr(jlls_pkg::IDX_LINK_PAGE, 8'h00);
      wr(jlls_pkg::IDX_CNT_CLEAR, 9'h040);
      rd(jlls_pkg::IDX_LANE2_STATE, 8'h00);
      rd(jlls_pkg::IDX_LANE3_STATE, 8'he0);
      wr(jlls_pkg::IDX_CNT_CLEAR, 9'h180);
      rd(jlls_pkg::IDX_LANE3_STATE, 8'h00);
      $display("error threshold and interrupt test done");
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #1_000_000;
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      rd(jlls_pkg::IDX_LANE2_STATE, jlls_pkg::STATE_RST);
      rd(jlls_pkg::IDX_LANE3_STATE, jlls_pkg::STATE_RST);
      rd(12'h0ff, 8'h00, jlls_pkg::RESP_SLVERR);
      wr(jlls_pkg::IDX_LANE2_STATE, 8'hff);
      rd(jlls_pkg::IDX_LANE2_STATE, 8'h00);
      $display("reset and access test done");
      t_state();
      t_err();
      give_verdict();
   end
endmodule
